//--- rtl/bcgs_pkg.sv
// Purpose: Shared constants for the bridge clock gating and error status block
// Assumes: APB register access with 32-bit data, byte addresses below
// Notes: Event bits are numbered in the order of the cause flags
package bcgs_pkg;
    // Register byte offsets
    localparam logic [7:0] BCGS_OFS_GATE = 8'h68; // Clock gate and cause flags
    localparam logic [7:0] BCGS_OFS_STOP = 8'h6c; // Clock stop protocol
    // Clock gate field layout
    localparam int BCGS_SLOT_NUM = 4; // Slot clocks with two-bit fields
    localparam int BCGS_DEV_BIT = 8; // On-board device clock disable
    localparam logic [1:0] BCGS_SLOT_OFF = 2'h3; // Code that stops a slot
    localparam logic [1:0] BCGS_SLOT_RST = 2'h0; // Slot field after reset
    localparam int BCGS_RSV_LO = 9; // Reserved field low bit
    localparam int BCGS_RSV_HI = 13; // Reserved field high bit
    localparam logic [4:0] BCGS_RSV_VAL = 5'h1f; // Reserved field value
    // Cause flags occupy bits 23:16
    localparam int BCGS_FLAG_LO = 16; // First cause flag
    localparam int BCGS_FLAG_NUM = 8; // Number of cause flags
    localparam logic [7:0] BCGS_FLAG_RST = 8'h00; // Flags after reset
    // Event index within the cause flags
    localparam int BCGS_EV_ADDR_PAR = 0; // Address parity, either bus
    localparam int BCGS_EV_PW_PAR = 1; // Posted write data parity
    localparam int BCGS_EV_PW_NODLV = 2; // Posted write not delivered
    localparam int BCGS_EV_PW_TABT = 3; // Target abort on posted write
    localparam int BCGS_EV_PW_MABT = 4; // Master abort on posted write
    localparam int BCGS_EV_DW_NODLV = 5; // Delayed write not delivered
    localparam int BCGS_EV_DR_NODATA = 6; // Delayed read got no data
    localparam int BCGS_EV_DT_MTO = 7; // Delayed transaction timeout
    // Attempt limit used by the core before it reports non-delivery
    localparam int BCGS_RETRY_LOG2 = 24; // Attempts are two to this power
    // Cycles a stop code must stand before its output is checked low
    localparam logic [5:0] BCGS_HOLD_CYC = 6'h28;
    // Clock stop register bits
    localparam int BCGS_STOP_STAT = 24; // Secondary clock stopped, read only
    localparam int BCGS_SEC_RUN_EN = 25; // Secondary stop protocol enable
    localparam int BCGS_PRI_KEEP = 26; // Keep primary clock running
    localparam int BCGS_PRI_RUN_EN = 27; // Primary stop protocol enable
    localparam int BCGS_RUN_MODE = 28; // Stop when secondary is idle and no primary request is pending
    localparam logic [3:0] BCGS_STOP_RST = 4'h0; // Bits 28:25 after reset
endpackage

//--- rtl/bcgs_top.sv
// Purpose: Secondary clock gating, error cause flags and clock stop control
// Assumes: pclk far faster than the secondary clock, which is sampled
// Notes: Registers reached over APB with zero wait states
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
//
// Behaviour
// - Slot code 11 holds clock low
// - Slot fields at bits 1:0 to 7:6
// - Bit 8 stops on-board device clock
// - Bits 13:9 read 1Fh, 15:14 zero
// - Bit 16 flags address parity error
// - Bit 17 flags posted write parity
// - Bit 18 flags posted write non-delivery
// - Bit 19 flags target abort, posted write
// - Bit 20 flags master abort, posted write
// - Bit 21 flags delayed write non-delivery
// - Bit 22 flags delayed read no data
// - Bit 23 flags delayed transaction timeout
// - Bit 24 shows secondary clock stopped
// - Bit 25 enables secondary stop protocol
// - Bit 26 keeps primary clock running
// - Bit 27 enables primary stop protocol
// - Bit 28 selects idle or requested stop
// - Error output needs enable, no disable
module bcgs_top #(
    parameter int SLOTS = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Secondary clock source and gated outputs
    input wire logic secondary_clock_in,
    output logic [SLOTS:0] secondary_slot_clock_out,
    // Error events from the bridge core, one-cycle pulses
    input wire logic [bcgs_pkg::BCGS_FLAG_NUM-1:0] error_event,
    input wire logic [bcgs_pkg::BCGS_FLAG_NUM-1:0] error_event_disable,
    input wire logic serr_enable,
    // Open-drain system error pin
    output logic primary_system_error_out,
    output logic primary_system_error_oe,
    // Clock stop handshake with the bridge core
    input wire logic primary_stop_request,
    input wire logic secondary_bus_idle,
    input wire logic primary_request_pending,
    output logic secondary_clock_stopped,
    output logic primary_clock_stop_allowed
);
    import bcgs_pkg::*;

    // Register state
    logic [2*SLOTS-1:0] slot_code_q; // Two-bit stop code per slot
    logic dev_off_q; // On-board device clock stop
    logic [BCGS_FLAG_NUM-1:0] flag_q; // Sticky error causes
    logic sec_run_en_q; // Secondary stop protocol enable
    logic pri_keep_q; // Keep primary clock running
    logic pri_run_en_q; // Primary stop protocol enable
    logic run_mode_q; // Idle-driven stop mode
    logic sec_stop_q; // Secondary clock stopped
    logic pri_allow_q; // Primary clock may stop
    logic serr_oe_q; // Error pin driven low
    logic [31:0] rdata_q; // Read data held for access phase
    logic slverr_q; // Unmapped address answer
    // Clock source sampling
    logic src_meta_q; // First synchroniser stage
    logic src_q; // Synchronised secondary clock
    logic [SLOTS:0] gate_en_q; // Per-output enable, changes when low
    logic [SLOTS:0] gate_en_d; // Wanted enable per output
    logic [SLOTS:0] clk_out_q; // Gated clock outputs
    // Bus decode
    logic setup_ph; // Setup cycle of a transfer
    logic wr_ph; // Write taking effect
    logic hit_gate; // Address selects gate register
    logic hit_stop; // Address selects stop register
    logic [BCGS_FLAG_NUM-1:0] reportable; // Events that reach the pin
    logic [BCGS_FLAG_NUM-1:0] flag_clr; // Write-one-to-clear mask
    logic sec_stop_d; // Next stopped state

    assign setup_ph = psel && !penable;
    assign wr_ph = psel && penable && pwrite;
    assign hit_gate = (paddr == BCGS_OFS_GATE);
    assign hit_stop = (paddr == BCGS_OFS_STOP);
    // Zero wait states keep the host path short
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = slverr_q;

    // Read data captured in setup so the access phase shows flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup_ph) begin
            slverr_q <= !(hit_gate || hit_stop);
            if (hit_gate && !pwrite) begin
                // Reserved fields are constants, not storage
                rdata_q <= {8'h00, flag_q, 2'h0, BCGS_RSV_VAL,
                    dev_off_q, slot_code_q};
            end else if (hit_stop && !pwrite) begin
                rdata_q <= {3'h0, run_mode_q, pri_run_en_q, pri_keep_q,
                    sec_run_en_q, sec_stop_q, 24'h00_0000};
            end else begin
                // Writes and unmapped reads return zero
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // Slot and device clock controls, low two byte lanes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_code_q <= {SLOTS{BCGS_SLOT_RST}};
            dev_off_q <= 1'b0;
        end else if (wr_ph && hit_gate) begin
            if (pstrb[0]) begin
                slot_code_q <= pwdata[2*SLOTS-1:0];
            end
            if (pstrb[1]) begin
                dev_off_q <= pwdata[BCGS_DEV_BIT];
            end
        end
    end

    // Clock stop controls sit in the top byte lane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {run_mode_q, pri_run_en_q, pri_keep_q, sec_run_en_q} <=
                BCGS_STOP_RST;
        end else if (wr_ph && hit_stop && pstrb[3]) begin
            sec_run_en_q <= pwdata[BCGS_SEC_RUN_EN];
            pri_keep_q <= pwdata[BCGS_PRI_KEEP];
            pri_run_en_q <= pwdata[BCGS_PRI_RUN_EN];
            run_mode_q <= pwdata[BCGS_RUN_MODE];
        end
    end

    // Only events the host allows may reach the pin or the flags
    assign reportable = serr_enable ? (error_event & ~error_event_disable)
        : '0;
    assign flag_clr = (wr_ph && hit_gate && pstrb[2])
        ? pwdata[BCGS_FLAG_LO +: BCGS_FLAG_NUM] : '0;

    // Sticky causes; a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= BCGS_FLAG_RST;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | reportable;
        end
    end

    // Error pin pulled low one cycle after each cycle with a reported event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serr_oe_q <= 1'b0;
        end else begin
            serr_oe_q <= |reportable;
        end
    end
    // Open-drain pin only ever drives low
    assign primary_system_error_out = 1'b0;
    assign primary_system_error_oe = serr_oe_q;

    // Secondary stop decision; disabled protocol keeps clocks running
    always_comb begin
        if (!sec_run_en_q) begin
            sec_stop_d = 1'b0;
        end else if (run_mode_q) begin
            sec_stop_d = secondary_bus_idle && !primary_request_pending;
        end else begin
            sec_stop_d = primary_stop_request;
        end
    end

    // Stop state and the primary clock permission
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_stop_q <= 1'b0;
            pri_allow_q <= 1'b0;
        end else begin
            sec_stop_q <= sec_stop_d;
            pri_allow_q <= pri_run_en_q && !pri_keep_q && sec_stop_q;
        end
    end
    assign secondary_clock_stopped = sec_stop_q;
    assign primary_clock_stop_allowed = pri_allow_q;

    // Secondary clock pin passes two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta_q <= 1'b0;
            src_q <= 1'b0;
        end else begin
            src_meta_q <= secondary_clock_in;
            src_q <= src_meta_q;
        end
    end

    // Wanted enable per output, stopped clock halts all of them
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_slot
            assign gate_en_d[gi] = !sec_stop_q &&
                (slot_code_q[2*gi +: 2] != BCGS_SLOT_OFF);
        end
    endgenerate
    assign gate_en_d[SLOTS] = !sec_stop_q && !dev_off_q;

    // Enables move only in the low phase, so no runt reaches a slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_en_q <= '0;
        end else if (!src_q) begin
            gate_en_q <= gate_en_d;
        end
    end

    // Gated outputs come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_q <= '0;
        end else begin
            clk_out_q <= {(SLOTS+1){src_q}} & gate_en_q;
        end
    end
    assign secondary_slot_clock_out = clk_out_q;

    // Check helpers: cycles the slot 0 and device stops have stood, saturating so no wrap
    logic [5:0] slot0_off_cnt_q; // Cycles slot 0 code has been 11
    logic [5:0] dev_off_cnt_q; // Cycles device stop has been set

    // Slot 0 hold counter, cleared whenever the code runs the clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot0_off_cnt_q <= 6'h00;
        end else if (slot_code_q[1:0] != BCGS_SLOT_OFF) begin
            slot0_off_cnt_q <= 6'h00;
        end else if (slot0_off_cnt_q != 6'h3f) begin
            slot0_off_cnt_q <= slot0_off_cnt_q + 6'h01;
        end
    end

    // Device hold counter, cleared whenever the device clock may run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_off_cnt_q <= 6'h00;
        end else if (!dev_off_q) begin
            dev_off_cnt_q <= 6'h00;
        end else if (dev_off_cnt_q != 6'h3f) begin
            dev_off_cnt_q <= dev_off_cnt_q + 6'h01;
        end
    end

    // Checks
    sequence s_gate_read;
        setup_ph && hit_gate && !pwrite;
    endsequence
    sequence s_slot0_off;
        slot_code_q[1:0] == BCGS_SLOT_OFF && !$stable(slot_code_q[1:0]);
    endsequence
    sequence s_slot0_low;
        !clk_out_q[0] [*8];
    endsequence

    a_slot_stop_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        slot0_off_cnt_q == BCGS_HOLD_CYC |=> s_slot0_low)
        else $error("slot 0 clock not held low");
    a_dev_stop_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        dev_off_cnt_q >= BCGS_HOLD_CYC |-> !secondary_slot_clock_out[SLOTS])
        else $error("device clock runs while stopped");
    a_slot_cnt_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_slot0_off |-> slot0_off_cnt_q == 6'h00)
        else $error("slot 0 hold count not restarted");
    a_slot_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ph && hit_gate && pstrb[0]
        |=> slot_code_q == $past(pwdata[2*SLOTS-1:0]))
        else $error("slot codes not written");
    a_dev_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ph && hit_gate && pstrb[1]
        |=> dev_off_q == $past(pwdata[BCGS_DEV_BIT]))
        else $error("device stop bit not written");
    a_unmapped_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && !(hit_gate || hit_stop) |=> pslverr)
        else $error("unmapped access not refused");
    a_gate_glitch_free: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$stable(gate_en_q) |-> !$past(src_q))
        else $error("clock gate changed in high phase");
    a_reserved_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_gate_read |=> prdata[13:9] == BCGS_RSV_VAL &&
            prdata[15:14] == 2'h0 && prdata[7:0] == $past(slot_code_q))
        else $error("clock gate readback wrong");
    a_flag_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        serr_enable && error_event[BCGS_EV_ADDR_PAR] &&
            !error_event_disable[BCGS_EV_ADDR_PAR]
        |=> flag_q[BCGS_EV_ADDR_PAR] && primary_system_error_oe)
        else $error("address parity flag or pin missed");
    a_flag_w1c: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ph && hit_gate && pstrb[2] && pwdata[23] && !reportable[7]
        |=> !flag_q[BCGS_EV_DT_MTO] [*2] or reportable[7])
        else $error("timeout flag not cleared");
    a_serr_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        !serr_enable |=> !primary_system_error_oe &&
            ((flag_q & ~$past(flag_q)) == '0))
        else $error("error reported while disabled");
    a_stop_status: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && hit_stop && !pwrite
        |=> prdata[BCGS_STOP_STAT] == $past(sec_stop_q))
        else $error("stop status readback wrong");
    a_idle_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        sec_run_en_q && run_mode_q && secondary_bus_idle &&
            !primary_request_pending |=> secondary_clock_stopped)
        else $error("idle secondary bus did not stop");
    a_run_disabled: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sec_run_en_q |=> !secondary_clock_stopped)
        else $error("clock stopped with protocol off");
    a_primary_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pri_keep_q || !pri_run_en_q) [*2] |-> !primary_clock_stop_allowed)
        else $error("primary stop allowed wrongly");
    a_primary_allow: assert property (
        @(posedge pclk) disable iff (!presetn)
        pri_run_en_q && !pri_keep_q && sec_stop_q
        |=> primary_clock_stop_allowed)
        else $error("primary stop not allowed");
endmodule

//--- test/bcgs_slot_model.sv
// Purpose: Secondary bus side, makes the clock source, watches slot clocks
// Assumes: Source clock runs free at 64 ns, phase unrelated to pclk
// Notes: A slot counts as running once a rising edge is seen after clear
`timescale 1ns/1ns
module bcgs_slot_model (
    // Gated clocks from the block
    input wire logic [4:0] slot_clk,
    input wire logic clr,
    // Source clock and edge record
    output logic src_clk,
    output logic [4:0] toggled
);
    // Free-running source, odd start offset to avoid pclk alignment
    initial begin
        src_clk = 1'b0;
        #7;
        forever begin
            #32 src_clk = ~src_clk;
        end
    end
    // One watcher per output; a held-low clock never sets its bit
    for (genvar g = 0; g < 5; g++) begin : g_w
        always @(posedge slot_clk[g] or posedge clr) begin
            if (clr) begin
                toggled[g] <= 1'b0;
            end else begin
                toggled[g] <= 1'b1;
            end
        end
    end
endmodule

//--- test/testbench.sv
// Purpose: Self-checking bench for clock gating, cause flags, clock stop
// Assumes: APB slave with pready from the block, 4 ns pclk
// Notes: Each scenario is a task that drives and judges on its own
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    import bcgs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, serr_enable = 1'b0, clr = 1'b0;
    logic [7:0] paddr = 8'h00, error_event = 8'h00, error_event_disable = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, rerr, sec_src, oe, pse_out, stopped, pri_ok;
    logic primary_stop_request = 1'b0, secondary_bus_idle = 1'b0;
    logic primary_request_pending = 1'b0;
    logic [4:0] slot_clk, toggled;
    int n_errors = 0, n_tests = 0, cyc = 0;
    always #2 pclk = ~pclk;
    bcgs_top bcgs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .secondary_clock_in(sec_src), .secondary_slot_clock_out(slot_clk),
        .error_event(error_event), .error_event_disable(error_event_disable),
        .serr_enable(serr_enable), .primary_system_error_out(pse_out),
        .primary_system_error_oe(oe),
        .primary_stop_request(primary_stop_request),
        .secondary_bus_idle(secondary_bus_idle),
        .primary_request_pending(primary_request_pending),
        .secondary_clock_stopped(stopped),
        .primary_clock_stop_allowed(pri_ok));
    bcgs_slot_model bcgs_slot_model_i (.slot_clk(slot_clk), .clr(clr),
        .src_clk(sec_src), .toggled(toggled));
    // Verdict in one place
    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard, well above the run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
        pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Clear the edge record, let four source periods pass, compare
    task automatic run_chk(input logic [4:0] exp);
        repeat (40) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (70) @(posedge pclk);
        `CHK("slot clocks", exp, toggled)
    endtask
    task automatic t_reset();
        apb(1'b0, BCGS_OFS_GATE, 32'h0, 4'h0);
        `CHK("gate reset", 32'h00003e00, rdata)
        apb(1'b0, BCGS_OFS_STOP, 32'h0, 4'h0);
        `CHK("stop reset", 32'h00000000, rdata)
        apb(1'b1, 8'h70, 32'hffffffff, 4'hf);
        `CHK("unmapped err", 1'b1, rerr)
        run_chk(5'h1f);
        $display("test reset done");
    endtask
    // Mixed codes per slot; lane-masked write keeps reserved bits fixed
    task automatic t_gate();
        logic [31:0] wd[3] = '{32'h11b, 32'h0c4, 32'hffff};
        logic [4:0] ex[3] = '{5'b01110, 5'b10111, 5'b00000};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, BCGS_OFS_GATE, wd[i], 4'h3);
            apb(1'b0, BCGS_OFS_GATE, 32'h0, 4'h0);
            `CHK("gate rd", (wd[i] & 32'h1ff) | 32'h3e00, rdata)
            run_chk(ex[i]);
        end
        apb(1'b1, BCGS_OFS_GATE, 32'h0, 4'h3);
        $display("test gate done");
    endtask
    // Each cause pulse sets its flag and one cycle of the error pin
    task automatic t_events();
        logic [31:0] f;
        serr_enable <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            f = 32'h1 << (16 + i);
            @(posedge pclk);
            error_event <= 8'h1 << i;
            @(posedge pclk);
            error_event <= 8'h00;
            #1 `CHK("oe on", 1'b1, oe)
            `CHK("pin low", 1'b0, pse_out)
            @(posedge pclk);
            #1 `CHK("oe off", 1'b0, oe)
            apb(1'b0, BCGS_OFS_GATE, 32'h0, 4'h0);
            `CHK("flag", f | 32'h3e00, rdata)
            apb(1'b1, BCGS_OFS_GATE, f, 4'h4);
            apb(1'b0, BCGS_OFS_GATE, 32'h0, 4'h0);
            `CHK("flag clr", 32'h3e00, rdata)
        end
        error_event_disable <= 8'h08;
        @(posedge pclk);
        error_event <= 8'h08;
        @(posedge pclk);
        serr_enable <= 1'b0;
        error_event <= 8'h01;
        // Event 3 was disabled, so the pin stays released
        #1 `CHK("oe dis", 1'b0, oe)
        @(posedge pclk);
        error_event <= 8'h00;
        @(posedge pclk);
        #1 `CHK("oe off en", 1'b0, oe)
        apb(1'b0, BCGS_OFS_GATE, 32'h0, 4'h0);
        `CHK("no flag", 32'h3e00, rdata)
        $display("test events done");
    endtask
    // Stop control through each mode and enable
    task automatic t_stop();
        apb(1'b1, BCGS_OFS_STOP, 32'h0a000000, 4'h8);
        primary_stop_request <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("stopped", 1'b1, stopped)
        `CHK("pri ok", 1'b1, pri_ok)
        apb(1'b0, BCGS_OFS_STOP, 32'h0, 4'h0);
        `CHK("stop rd", 32'h0b000000, rdata)
        run_chk(5'h00);
        apb(1'b1, BCGS_OFS_STOP, 32'h0e000000, 4'h8);
        repeat (4) @(posedge pclk);
        `CHK("keep pri", 1'b0, pri_ok)
        apb(1'b1, BCGS_OFS_STOP, 32'h12000000, 4'h8);
        primary_stop_request <= 1'b0;
        secondary_bus_idle <= 1'b1;
        primary_request_pending <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("pending", 1'b0, stopped)
        primary_request_pending <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("idle stop", 1'b1, stopped)
        `CHK("pri off", 1'b0, pri_ok)
        apb(1'b1, BCGS_OFS_STOP, 32'h10000000, 4'h8);
        repeat (4) @(posedge pclk);
        `CHK("sec off", 1'b0, stopped)
        $display("test stop done");
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gate();
        t_events();
        t_stop();
        end_sim();
    end
endmodule
